//--- hw/trl_map.svh
`ifndef TRL_MAP_SVH
`define TRL_MAP_SVH

// ====================================================
// port addresses on port_select_high/low
`define TRL_PORT_CMD        2'h3

// ====================================================
// command byte fields
`define TRL_CMD_SEL_HI      7
`define TRL_CMD_SEL_LO      6
`define TRL_CMD_RW_HI       5
`define TRL_CMD_RW_LO       4
`define TRL_CMD_RB_COUNT_N  5
`define TRL_CMD_RB_STATUS_N 4
`define TRL_CMD_RB_SEL_HI   3
`define TRL_CMD_RB_SEL_LO   1
`define TRL_CMD_MODE_HI     5
`define TRL_CMD_SEL_READBK  2'h3
`define TRL_CMD_RW_LATCH    2'h0

// ====================================================
// byte formats in the access field
`define TRL_FMT_LSB         2'h1
`define TRL_FMT_MSB         2'h2
`define TRL_FMT_BOTH        2'h3

// ====================================================
// status byte layout and reset values
`define TRL_STS_OUT_BIT     7
`define TRL_STS_PEND_BIT    6
`define TRL_MODE_RESET      6'h00
`define TRL_BYTE_RESET      8'h00
`define TRL_COUNT_RESET     16'h0000

`endif

//--- hw/trl_pkg.sv
package trl_pkg;

    // signals from the counting part of one counter
    typedef struct packed {
        logic [15:0] live_count;
        logic        out_level;
        logic        load_done;
    } trl_cnt_in_type;

    // one counter's read-side state shown to the unit
    typedef struct packed {
        logic [5:0] mode;
        logic       pending_load;
        logic       count_latched;
        logic       status_latched;
    } trl_cnt_out_type;

endpackage

//--- hw/trl_readback.sv
`timescale 1ns/1ps
`default_nettype none

`include "trl_map.svh"

// Function
// [RL1] host stops a counter's clock before a plain unlatched read
// [RL2] command write with bits 5 and 4 zero is a latch-count command
// [RL3] top two command bits pick counter 0, 1, 2 or read-back
// [RL4] latch holds count until read or reprogrammed, then follows live count
// [RL5] further latch-count commands ignored while a latched count is unread
// [RL6] latching never changes mode or counting; several counters may be latched
// [RL7] reads follow byte format; read byte position kept per counter
// [RL8] read byte order tracked apart from write byte order
// [RL9] host must not interleave two readers of one two-byte counter
// [RL10] read-back acts on counters whose select bits 3..1 are one
// [RL11] read-back with count bit zero latches count of each selected counter
// [RL12] reading a counter releases only that counter's latch
// [RL13] repeated count read-backs before a read are ignored
// [RL14] read-back with status bit zero latches status; read via data port
// [RL15] status holds output level, pending-load flag and last mode field
// [RL16] control word sets pending-load only for the addressed counter
// [RL17] count write sets pending-load; two-byte format on second byte
// [RL18] pending-load clears when the held count moves to the counting stage
// [RL19] repeated status latches before a read are ignored
// [RL20] count and status latched together, each skipped if already latched
// [RL21] with both latched, status reads first, then count, then live count
// [RL22] unlatched read returns live count in format byte order
module trl_readback
    import trl_pkg::*;
#(
    parameter int NUM_CNT = 3
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // host port
    input  wire logic                  cs_n,
    input  wire logic                  rd_n,
    input  wire logic                  wr_n,
    input  wire logic                  port_select_high,
    input  wire logic                  port_select_low,
    input  wire logic [7:0]            data_in,
    output logic      [7:0]            data_out,
    output logic                       data_oe_n,
    // counting part
    input  wire trl_cnt_in_type        cnt_in  [NUM_CNT],
    output trl_cnt_out_type            cnt_out [NUM_CNT]
);

    // ====================================================
    // decode helpers
    function automatic logic [2:0] trl_onehot(input logic [1:0] idx);
        trl_onehot = (idx == 2'h0) ? 3'h1 :
                     (idx == 2'h1) ? 3'h2 :
                     (idx == 2'h2) ? 3'h4 : 3'h0;
    endfunction

    // ====================================================
    // strobe edge detection
    logic       wr_act;
    logic       rd_act;
    logic       wr_act_q;
    logic       rd_act_q;
    logic       wr_go;
    logic       rd_go;
    logic [1:0] port_idx;
    logic       port_is_cmd;

    assign port_idx    = {port_select_high, port_select_low};
    assign port_is_cmd = (port_idx == `TRL_PORT_CMD);
    assign wr_act      = !cs_n && !wr_n && rd_n;
    assign rd_act      = !cs_n && !rd_n && wr_n && !port_is_cmd;
    assign wr_go       = wr_act && !wr_act_q;
    assign rd_go       = rd_act && !rd_act_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
        end else begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
        end
    end

    // ====================================================
    // command decode
    logic       cmd_wr;
    logic [1:0] cmd_sel;
    logic [1:0] cmd_rw;
    logic       cmd_readback;
    logic       cmd_latch;
    logic       cmd_ctrl;
    logic [2:0] cmd_target;
    logic [2:0] rb_target;
    logic       rb_count;
    logic       rb_status;
    logic [2:0] data_target;

    assign cmd_wr       = wr_go && port_is_cmd;
    assign cmd_sel      = data_in[`TRL_CMD_SEL_HI:`TRL_CMD_SEL_LO];                // [RL3]
    assign cmd_rw       = data_in[`TRL_CMD_RW_HI:`TRL_CMD_RW_LO];
    assign cmd_readback = cmd_wr && (cmd_sel == `TRL_CMD_SEL_READBK);             // [RL3]
    assign cmd_latch    = cmd_wr && !cmd_readback && (cmd_rw == `TRL_CMD_RW_LATCH); // [RL2]
    assign cmd_ctrl     = cmd_wr && !cmd_readback && (cmd_rw != `TRL_CMD_RW_LATCH);
    assign cmd_target   = trl_onehot(cmd_sel);
    assign rb_target    = data_in[`TRL_CMD_RB_SEL_HI:`TRL_CMD_RB_SEL_LO];           // [RL10]
    assign rb_count     = cmd_readback && !data_in[`TRL_CMD_RB_COUNT_N];           // [RL11]
    assign rb_status    = cmd_readback && !data_in[`TRL_CMD_RB_STATUS_N];          // [RL14]
    // data reads and writes never aim at the command port
    assign data_target  = port_is_cmd ? 3'h0 : trl_onehot(port_idx);

    // ====================================================
    // per-counter read state
    logic [7:0] rd_byte [NUM_CNT];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            // ====================================================
            // state held per counter
            logic [5:0]  mode_q;
            logic        pend_q;
            logic        cnt_lat_q;
            logic [15:0] cnt_hold_q;
            logic        sts_lat_q;
            logic [7:0]  sts_hold_q;
            logic        rd_msb_q;
            logic        wr_msb_q;
            logic [1:0]  fmt;
            logic        do_ctrl;
            logic        do_cnt_lat;
            logic        do_sts_lat;
            logic        do_wr;
            logic        do_rd;
            logic        pend_set;
            logic        rd_status;
            logic        rd_hi;
            logic        rd_last;
            logic [15:0] view;
            logic [7:0]  sts_now;
            logic        two_byte;
            logic        rel_cnt;
            logic        rel_sts;
            logic        rd_step;
            logic        wr_step;

            // ====================================================
            // per-counter decode
            assign fmt        = mode_q[`TRL_CMD_MODE_HI:`TRL_CMD_RW_LO];
            assign two_byte   = (fmt == `TRL_FMT_BOTH);
            assign do_ctrl    = cmd_ctrl && cmd_target[gi];
            // a held count or status is overwritten only after it is read or its counter is reprogrammed
            assign do_cnt_lat = ((cmd_latch && cmd_target[gi])                    // [RL2]
                                || (rb_count && rb_target[gi]))                  // [RL11] [RL20]
                                && !cnt_lat_q;                                   // [RL5] [RL13]
            assign do_sts_lat = rb_status && rb_target[gi] && !sts_lat_q;        // [RL19] [RL20]
            assign do_wr      = wr_go && data_target[gi];
            assign do_rd      = rd_go && data_target[gi];
            assign pend_set   = do_ctrl                                          // [RL16]
                                || (do_wr && (fmt != `TRL_FMT_BOTH || wr_msb_q)); // [RL17]
            assign rd_status  = sts_lat_q;                                       // [RL21]
            assign rd_hi      = (fmt == `TRL_FMT_MSB) || (fmt == `TRL_FMT_BOTH && rd_msb_q);
            assign rd_last    = (fmt != `TRL_FMT_BOTH) || rd_msb_q;
            assign view       = cnt_lat_q ? cnt_hold_q : cnt_in[gi].live_count;   // [RL22]
            assign sts_now    = {cnt_in[gi].out_level, pend_q, mode_q};          // [RL15]
            assign rd_byte[gi] = rd_status ? sts_hold_q :
                                 (rd_hi ? view[15:8] : view[7:0]);               // [RL7]

            // count latch frees on its last count byte, status on any read
            assign rel_cnt    = do_rd && !rd_status && rd_last;                  // [RL12]
            assign rel_sts    = do_rd && rd_status;                              // [RL21]
            assign rd_step    = do_rd && !rd_status && two_byte;                 // [RL8]
            assign wr_step    = do_wr && two_byte;                               // [RL8]

            // ====================================================
            // mode and pending-load flag
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    mode_q <= `TRL_MODE_RESET;
                end else if (do_ctrl) begin
                    mode_q <= data_in[`TRL_CMD_MODE_HI:0];                       // [RL6]
                end
            end

            // set wins over the load-done clear
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    pend_q <= 1'b0;
                end else if (pend_set) begin
                    pend_q <= 1'b1;
                end else if (cnt_in[gi].load_done) begin
                    pend_q <= 1'b0;                                              // [RL18]
                end
            end

            // ====================================================
            // count hold latch
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    cnt_lat_q <= 1'b0;
                end else if (do_ctrl) begin
                    cnt_lat_q <= 1'b0;                                           // [RL4]
                end else if (do_cnt_lat) begin
                    cnt_lat_q <= 1'b1;                                           // [RL4]
                end else if (rel_cnt) begin
                    cnt_lat_q <= 1'b0;                                           // [RL12]
                end
            end

            // hold register loads only on an accepted latch
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    cnt_hold_q <= `TRL_COUNT_RESET;
                end else if (do_cnt_lat) begin
                    cnt_hold_q <= cnt_in[gi].live_count;                         // [RL5]
                end
            end

            // ====================================================
            // status hold latch
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    sts_lat_q <= 1'b0;
                end else if (do_ctrl) begin
                    sts_lat_q <= 1'b0;
                end else if (do_sts_lat) begin
                    sts_lat_q <= 1'b1;                                           // [RL14]
                end else if (rel_sts) begin
                    sts_lat_q <= 1'b0;                                           // [RL21]
                end
            end

            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    sts_hold_q <= `TRL_BYTE_RESET;
                end else if (do_sts_lat) begin
                    sts_hold_q <= sts_now;                                       // [RL19]
                end
            end

            // ====================================================
            // read and write byte positions, kept apart
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    rd_msb_q <= 1'b0;
                    wr_msb_q <= 1'b0;
                end else if (do_ctrl) begin
                    rd_msb_q <= 1'b0;
                    wr_msb_q <= 1'b0;
                end else begin
                    if (rd_step) begin
                        rd_msb_q <= !rd_msb_q;                                   // [RL8]
                    end
                    if (wr_step) begin
                        wr_msb_q <= !wr_msb_q;                                   // [RL8]
                    end
                end
            end

            // ====================================================
            // registered view for the counting part
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    cnt_out[gi] <= '0;
                end else begin
                    cnt_out[gi].mode           <= mode_q;
                    cnt_out[gi].pending_load   <= pend_q;
                    cnt_out[gi].count_latched  <= cnt_lat_q;
                    cnt_out[gi].status_latched <= sts_lat_q;
                end
            end
        end
    endgenerate

    // ====================================================
    // host data output
    logic [7:0] rd_sel;

    // command port reads never start, so the index stays in range
    assign rd_sel = (port_idx < 2'(NUM_CNT)) ? rd_byte[port_idx] : `TRL_BYTE_RESET;

    // drive enable follows the qualified read strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            data_oe_n <= 1'b1;
        end else begin
            data_oe_n <= !rd_act;
        end
    end

    // read byte captured once per read, then held
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            data_out <= `TRL_BYTE_RESET;
        end else if (rd_go) begin
            data_out <= rd_sel;                                                  // [RL7]
        end
    end

endmodule

`default_nettype wire

//--- test/trl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module trl_host_model (
    // bus
    input  wire logic       clk_sys,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic [1:0]      port,
    output logic [7:0]      data_in,
    input  wire logic [7:0] data_out
);
    initial begin
        cs_n    = 1'b1;
        rd_n    = 1'b1;
        wr_n    = 1'b1;
        port    = 2'h0;
        data_in = 8'h5a;
    end
    // one caller at a time, two-byte reads never split
    task automatic wr(input logic [1:0] p, input logic [7:0] d);
        @(posedge clk_sys);
        cs_n    <= 1'b0;
        wr_n    <= 1'b0;
        port    <= p;
        data_in <= d;
        @(posedge clk_sys);
        cs_n    <= 1'b1;
        wr_n    <= 1'b1;
        data_in <= ~d;
    endtask
    // counts are held still by the caller before unlatched reads
    task automatic rd(input logic [1:0] p, output logic [7:0] d);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        port <= p;
        @(posedge clk_sys);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        @(negedge clk_sys);
        d = data_out;
    endtask
endmodule
`default_nettype wire

//--- test/trl_readback_sva.sv
`timescale 1ns/1ps
`default_nettype none
module trl_readback_chk
    import trl_pkg::*;
#(
    parameter int NUM_CNT = 3
) (
    // host side
    input wire logic            clk_sys,
    input wire logic            rstn,
    input wire logic            cs_n,
    input wire logic            rd_n,
    input wire logic            wr_n,
    input wire logic            port_select_high,
    input wire logic            port_select_low,
    input wire logic [7:0]      data_in,
    input wire logic [7:0]      data_out,
    input wire logic            data_oe_n,
    // counters
    input wire trl_cnt_in_type  cnt_in  [NUM_CNT],
    input wire trl_cnt_out_type cnt_out [NUM_CNT]
);
    logic      rd_q;
    logic      wr_q;
    wire logic cmd  = port_select_high & port_select_low;
    wire logic rd_c = !cs_n & !rd_n & wr_n & !cmd;
    wire logic wr_c = !cs_n & !wr_n & rd_n;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= rd_c;
            wr_q <= wr_c;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence cmd_s; wr_c && !wr_q && cmd; endsequence
    sequence cw1_s; cmd_s ##0 data_in[7:6] == 2'h1 && data_in[5:4] != 2'h0; endsequence
    sequence other_s; cmd_s ##0 (data_in[7:6] == 2'h3 || data_in[5:4] == 2'h0); endsequence
    oe_follow_a: assert property (1'b1 |=> data_oe_n == !$past(rd_c))
        else $error("output enable wrong");
    out_hold_a: assert property (!(rd_c && !rd_q) |=> $stable(data_out))
        else $error("read byte changed without read");
    cw_pend_a: assert property (cw1_s |-> ##2 cnt_out[1].pending_load)
        else $error("pending flag not set");
    pend_other_a: assert property (cw1_s ##0 !cnt_in[0].load_done |-> ##2 $stable(cnt_out[0].pending_load))
        else $error("pending flag of other counter moved");
    cw_mode_a: assert property (cw1_s |-> ##2 cnt_out[1].mode == $past(data_in[5:0], 2))
        else $error("mode field wrong");
    latch_flag_a: assert property (cmd_s ##0 data_in[7:4] == 4'h8 |-> ##2 cnt_out[2].count_latched)
        else $error("latch command missed");
    rb_count_a: assert property (cmd_s ##0 data_in[7:5] == 3'h6 && data_in[3] |-> ##2 cnt_out[2].count_latched)
        else $error("read-back count missed");
    rb_status_a: assert property (cmd_s ##0 data_in[7:6] == 2'h3 && !data_in[4] && data_in[1] |-> ##2 cnt_out[0].status_latched)
        else $error("read-back status missed");
    mode_keep_a: assert property (other_s |-> ##2 $stable(cnt_out[0].mode))
        else $error("mode disturbed");
    load_clear_a: assert property (cnt_in[0].load_done && !(wr_c && !wr_q) |-> ##2 !cnt_out[0].pending_load)
        else $error("pending flag not cleared");
endmodule
bind trl_readback trl_readback_chk #(.NUM_CNT(NUM_CNT)) u_chk (
    .clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select_high(port_select_high), .port_select_low(port_select_low),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .cnt_in(cnt_in), .cnt_out(cnt_out)
);
`default_nettype wire

//--- test/trl_readback_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module trl_readback_tb
    import trl_pkg::*;
();
    logic            clk_sys, rstn, cs_n, rd_n, wr_n, data_oe_n;
    logic [1:0]      port;
    logic [7:0]      data_in, data_out, b, cw [3];
    logic [15:0]     v [3];
    logic [31:0]     rnd;
    int              miscompares, check_count, cyc;
    trl_cnt_in_type  cin [3];
    trl_cnt_out_type cout [3];
    trl_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .port(port), .data_in(data_in), .data_out(data_out));
    trl_readback #(.NUM_CNT(3)) dut (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .port_select_high(port[1]), .port_select_low(port[0]),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .cnt_in(cin),
        .cnt_out(cout));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] sts(input logic o, input logic p, input logic [7:0] c);
        return {o, p, c[5:0]};
    endfunction
    task automatic rdc(input logic [1:0] p, input logic [7:0] e, input string nm);
        host.rd(p, b);
        `CHK(nm, e, b)
    endtask
    task automatic conclude();
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        rstn = 1'b0;
        rnd  = 32'h00004347;
        for (int k = 0; k < 3; k++) begin
            cin[k] = '0;
        end
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            rnd   = nxt(rnd);
            cw[k] = {k[1:0], 2'h3, rnd[3:0]};
            host.wr(2'h3, cw[k]);
            host.wr(k[1:0], rnd[11:4]);
            host.wr(k[1:0], rnd[19:12]);
        end
        for (int k = 0; k < 3; k++) begin
            rnd = nxt(rnd);
            v[k] = rnd[15:0];
            cin[k].live_count <= v[k];
            host.wr(2'h3, {k[1:0], 2'h0, rnd[19:16]});
            cin[k].live_count <= rnd[31:16];
            host.wr(2'h3, {k[1:0], 6'h0});
            rdc(k[1:0], v[k][7:0], "latched lsb");
            host.wr(k[1:0], 8'h3c);
            rdc(k[1:0], v[k][15:8], "latched msb");
            rdc(k[1:0], rnd[23:16], "live lsb");
            rdc(k[1:0], rnd[31:24], "live msb");
            host.wr(k[1:0], 8'hc3);
        end
        rnd = nxt(rnd);
        for (int k = 0; k < 3; k++) begin
            v[k] = rnd[k*8 +: 16];
            cin[k].live_count <= v[k];
        end
        host.wr(2'h3, 8'hde);
        for (int k = 0; k < 3; k++) begin
            cin[k].live_count <= ~v[k];
        end
        host.wr(2'h3, 8'hde);
        rdc(2'h1, v[1][7:0], "rb lsb1");
        rdc(2'h0, v[0][7:0], "rb lsb0");
        rdc(2'h1, v[1][15:8], "rb msb1");
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("kept", 3'h5, {cout[0].count_latched, cout[1].count_latched, cout[2].count_latched})
        rdc(2'h0, v[0][15:8], "rb msb0");
        rdc(2'h2, v[2][7:0], "rb lsb2");
        rdc(2'h2, v[2][15:8], "rb msb2");
        @(posedge clk_sys);
        cin[0].out_level <= 1'b1;
        host.wr(2'h3, 8'hc2);
        cin[0].out_level <= 1'b0;
        host.wr(2'h3, 8'he2);
        rdc(2'h0, sts(1'b1, 1'b1, cw[0]), "status");
        rdc(2'h0, ~v[0][7:0], "cnt lsb");
        rdc(2'h0, ~v[0][15:8], "cnt msb");
        @(posedge clk_sys);
        cin[0].load_done <= 1'b1;
        @(posedge clk_sys);
        cin[0].load_done <= 1'b0;
        host.wr(2'h3, 8'he2);
        rdc(2'h0, sts(1'b0, 1'b0, cw[0]), "loaded");
        cw[2] = 8'h90;
        host.wr(2'h3, cw[2]);
        host.wr(2'h3, 8'he2);
        rdc(2'h0, sts(1'b0, 1'b0, cw[0]), "other");
        host.wr(2'h3, 8'he8);
        rdc(2'h2, sts(1'b0, 1'b1, cw[2]), "addressed");
        rdc(2'h2, ~v[2][7:0], "lsb only");
        rdc(2'h2, ~v[2][7:0], "lsb again");
        host.wr(2'h3, 8'ha0);
        rdc(2'h2, ~v[2][15:8], "msb only");
        host.wr(2'h3, 8'h80);
        cin[2].live_count <= v[2];
        host.wr(2'h3, 8'ha0);
        rdc(2'h2, v[2][15:8], "reprogram");
        conclude();
    end
endmodule
`default_nettype wire
